// >>> smc_supply_monitor.sv
`timescale 1ns/100ps
module smc_supply_monitor
   import smc_pkg::*;
#(
   parameter int QUAL_CYCLES = SMC_QUAL_CYC
) (
   input  wire logic          core_clk,
   input  wire logic          reset,
   input  wire smc_sfr_req_t  sfr_req,
   input  wire logic          irq_enable_priority_second,
   input  wire logic          dig_cmp_raw,
   input  wire logic          ana_cmp_raw,
   output      logic [7:0]    sfr_rdata,
   output      smc_cmp_ctrl_t cmp_ctrl,
   output      logic          low_supply_irq
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   // comparator input synchronisers, digital supply in bit 1
   logic [1:0]  sync1;
   logic [1:0]  sync2;

   // glitch filter outputs and run counters
   logic [1:0]  filt;
   logic [1:0]  next_filt;
   logic [2:0]  glitch_cnt [2];
   logic [2:0]  next_glitch_cnt [2];

   // control register fields
   logic [1:0]  digital_trip_select;
   logic [1:0]  next_digital_trip_select;
   logic [1:0]  analog_trip_select;
   logic [1:0]  next_analog_trip_select;
   logic        monitor_on;
   logic        next_monitor_on;

   // sticky flag and its qualification timer
   logic        low_supply_flag;
   logic        next_low_supply_flag;
   logic [31:0] qual_cnt;
   logic [31:0] next_qual_cnt;
   smc_state_t  state;
   smc_state_t  next_state;

   // decoded conditions
   logic        digital_supply_ok;
   logic        analog_supply_ok;
   logic        ctrl_wr;
   logic        any_low;

   // output register inputs
   logic [7:0]  next_rdata;
   logic        next_irq;

   // filtered comparator views and register decode
   // any_low is gated by the enable, so a disabled monitor never sets the flag
   assign digital_supply_ok = filt[1];
   assign analog_supply_ok  = filt[0];
   assign any_low = monitor_on && !(digital_supply_ok && analog_supply_ok);
   assign ctrl_wr = sfr_req.wr && (sfr_req.addr == SMC_CTRL_ADDR);

   // -------------------------------------------------------------------
   // comparator synchronisers
   // -------------------------------------------------------------------
   // two flops, comparators are asynchronous to core_clk
   // reset to supply ok so no false low follows reset
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync1 <= SMC_CMP_RESET;
         sync2 <= SMC_CMP_RESET;
      end else begin
         sync1 <= {dig_cmp_raw, ana_cmp_raw};
         sync2 <= sync1;
      end
   end

   // -------------------------------------------------------------------
   // glitch filter, one per comparator
   // -------------------------------------------------------------------
   generate
      for (genvar i = 0; i < 2; i++) begin : g_filt
         // count synced samples that differ from the filtered level
         // the filter is symmetric, a recovery is delayed as much as a drop
         always_comb begin
            next_glitch_cnt[i] = 3'h0;
            next_filt[i]       = filt[i];
            if (sync2[i] != filt[i]) begin
               if (glitch_cnt[i] == SMC_GLITCH_MAX) begin
                  next_filt[i] = sync2[i];
               end else begin
                  next_glitch_cnt[i] = glitch_cnt[i] + 3'h1;
               end
            end
         end
         // filter registers
         // filtered level starts at supply ok, like the synchronisers
         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               glitch_cnt[i] <= 3'h0;
               filt[i]       <= SMC_CMP_RESET[i];
            end else begin
               glitch_cnt[i] <= next_glitch_cnt[i];
               filt[i]       <= next_filt[i];
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // control register, flag and qualification
   // -------------------------------------------------------------------
   // next values of the register fields and the flag timer
   // order matters: write, then qualification clear, then hardware set
   always_comb begin
      next_digital_trip_select = digital_trip_select;
      next_analog_trip_select  = analog_trip_select;
      next_monitor_on          = monitor_on;
      next_low_supply_flag     = low_supply_flag;
      next_qual_cnt            = qual_cnt;
      next_state               = state;
      if (ctrl_wr) begin
         next_digital_trip_select = sfr_req.wdata[SMC_BIT_DTRIP +: 2];
         next_analog_trip_select  = sfr_req.wdata[SMC_BIT_ATRIP +: 2];
         next_monitor_on          = sfr_req.wdata[SMC_BIT_ON];
         next_low_supply_flag     = sfr_req.wdata[SMC_BIT_FLAG];
      end
      // qualification timer, runs only while the flag waits to clear
      // any drop of a supply or a software clear sends it back to idle
      // the counter is wide enough for the full qualification span
      case (state)
         SMC_IDLE: begin
            next_qual_cnt = 32'h0;
            if (low_supply_flag && monitor_on && !any_low) begin
               next_state = SMC_QUAL;
            end
         end
         SMC_QUAL: begin
            if (!monitor_on || any_low || !low_supply_flag) begin
               next_state    = SMC_IDLE;
               next_qual_cnt = 32'h0;
            end else if (qual_cnt == 32'(QUAL_CYCLES - 1)) begin
               next_low_supply_flag = 1'b0;
               next_state           = SMC_IDLE;
               next_qual_cnt        = 32'h0;
            end else begin
               next_qual_cnt = qual_cnt + 32'h1;
            end
         end
         default: begin
            next_state    = SMC_IDLE;
            next_qual_cnt = 32'h0;
         end
      endcase
      // hardware set wins over any clear
      if (any_low) begin
         next_low_supply_flag = 1'b1;
      end
      if (!monitor_on) begin
         next_qual_cnt = 32'h0;
         next_state    = SMC_IDLE;
      end
   end

   // control and flag registers
   // reset values come from the register's power-on image
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         digital_trip_select <= SMC_CTRL_RESET[SMC_BIT_DTRIP +: 2];
         analog_trip_select  <= SMC_CTRL_RESET[SMC_BIT_ATRIP +: 2];
         monitor_on          <= SMC_CTRL_RESET[SMC_BIT_ON];
         low_supply_flag     <= SMC_CTRL_RESET[SMC_BIT_FLAG];
         qual_cnt            <= 32'h0;
         state               <= SMC_IDLE;
      end else begin
         digital_trip_select <= next_digital_trip_select;
         analog_trip_select  <= next_analog_trip_select;
         monitor_on          <= next_monitor_on;
         low_supply_flag     <= next_low_supply_flag;
         qual_cnt            <= next_qual_cnt;
         state               <= next_state;
      end
   end

   // -------------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------------
   // register image and interrupt request
   // live bits show filtered comparators even while the monitor is off
   always_comb begin
      next_rdata = {digital_supply_ok, analog_supply_ok, low_supply_flag,
                    digital_trip_select, analog_trip_select, monitor_on};
      next_irq   = low_supply_flag && irq_enable_priority_second;
   end

   // output flops, cmp_ctrl leads the image by one edge
   // so the comparators see a new trip level as early as possible
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sfr_rdata      <= SMC_CTRL_RESET;
         cmp_ctrl       <= '{dig_trip: SMC_CTRL_RESET[SMC_BIT_DTRIP +: 2],
                             ana_trip: SMC_CTRL_RESET[SMC_BIT_ATRIP +: 2],
                             on:       SMC_CTRL_RESET[SMC_BIT_ON]};
         low_supply_irq <= 1'b0;
      end else begin
         sfr_rdata      <= next_rdata;
         cmp_ctrl       <= '{dig_trip: next_digital_trip_select,
                             ana_trip: next_analog_trip_select,
                             on:       next_monitor_on};
         low_supply_irq <= next_irq;
      end
   end

endmodule : smc_supply_monitor

// >>> smc_pkg.sv
package smc_pkg;

   // -------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------
   localparam logic [7:0] SMC_CTRL_ADDR   = 8'hDF;
   localparam logic [7:0] SMC_CTRL_RESET  = 8'hDE;
   localparam logic [1:0] SMC_CMP_RESET   = 2'h3; // synchronisers and filters start at supply ok
   localparam int         SMC_BIT_DIG_OK  = 7;
   localparam int         SMC_BIT_ANA_OK  = 6;
   localparam int         SMC_BIT_FLAG    = 5;
   localparam int         SMC_BIT_DTRIP   = 3;
   localparam int         SMC_BIT_ATRIP   = 1;
   localparam int         SMC_BIT_ON      = 0;

   // -------------------------------------------------------------------
   // trip level codes
   // -------------------------------------------------------------------
   localparam logic [1:0] SMC_TRIP_4V63   = 2'h0;
   localparam logic [1:0] SMC_TRIP_3V08   = 2'h1;
   localparam logic [1:0] SMC_TRIP_2V93   = 2'h2;
   localparam logic [1:0] SMC_TRIP_2V63   = 2'h3;

   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int         SMC_CLK_HZ      = 100_000_000;
   localparam int         SMC_QUAL_MS     = 250;
   localparam int         SMC_QUAL_CYC    = SMC_CLK_HZ / 1000 * SMC_QUAL_MS;
   localparam int         SMC_GLITCH_CYC  = 4;
   localparam logic [2:0] SMC_GLITCH_MAX  = 3'(SMC_GLITCH_CYC - 1);

   // -------------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } smc_sfr_req_t;

   typedef struct packed {
      logic [1:0] dig_trip;
      logic [1:0] ana_trip;
      logic       on;
   } smc_cmp_ctrl_t;

   typedef enum logic [1:0] {
      SMC_IDLE = 2'b01,
      SMC_QUAL = 2'b10
   } smc_state_t;

endpackage : smc_pkg

// >>> smc_supply_monitor_checker.sv
`timescale 1ns/100ps
module smc_supply_monitor_checker
   import smc_pkg::*;
#(parameter int QUAL_CYCLES = SMC_QUAL_CYC) (
   input wire logic          core_clk,
   input wire logic          reset,
   input wire smc_sfr_req_t  sfr_req,
   input wire logic          irq_enable_priority_second,
   input wire logic          dig_cmp_raw,
   input wire logic          ana_cmp_raw,
   input wire logic [7:0]    sfr_rdata,
   input wire smc_cmp_ctrl_t cmp_ctrl,
   input wire logic          low_supply_irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   int ok_cnt;
   int next_ok_cnt;
   // run of samples with both supplies ok, flag up, monitor on
   assign next_ok_cnt = (&sfr_rdata[7:5] && sfr_rdata[0]) ? ok_cnt + 1 : 0;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) ok_cnt <= 0;
      else ok_cnt <= next_ok_cnt;
   end
   sequence sfr_wr;
      sfr_req.wr && sfr_req.addr == SMC_CTRL_ADDR;
   endsequence
   irq_gate_a: assert property (low_supply_irq == (sfr_rdata[5] && $past(irq_enable_priority_second)))
      else $error("irq does not follow flag and enable");
   ctrl_follow_a: assert property (sfr_wr |=> cmp_ctrl == $past(sfr_req.wdata[4:0]))
      else $error("comparator control not written");
   reg_image_a: assert property (sfr_wr |-> ##2 sfr_rdata[4:0] == $past(sfr_req.wdata[4:0], 2))
      else $error("register image wrong after write");
   glitch_filter_a: assert property ($fell(sfr_rdata[7]) |-> !$past(dig_cmp_raw, 4) && !$past(dig_cmp_raw, 5))
      else $error("short comparator pulse passed filter");
   flag_set_a: assert property ($fell(sfr_rdata[7]) && sfr_rdata[0] |-> ##[0:2] sfr_rdata[5])
      else $error("flag not set on low supply");
   no_clear_a: assert property (!sfr_rdata[7] && sfr_rdata[5] && sfr_rdata[0]
      && !($past(sfr_req.wr) && !$past(sfr_req.wdata[0])) |=> sfr_rdata[5])
      else $error("flag cleared while supply low");
   qual_min_a: assert property ($fell(sfr_rdata[5]) && !$past(sfr_req.wr) && !$past(sfr_req.wr, 2)
      |-> ok_cnt >= QUAL_CYCLES)
      else $error("flag cleared before qualification");
   qual_max_a: assert property (ok_cnt <= QUAL_CYCLES + 3)
      else $error("flag not cleared after qualification");
   off_hold_a: assert property (!sfr_rdata[0] && !sfr_rdata[5] && !$past(sfr_req.wr) |=> !sfr_rdata[5])
      else $error("flag set while monitor off");
endmodule : smc_supply_monitor_checker

bind smc_supply_monitor smc_supply_monitor_checker #(.QUAL_CYCLES(QUAL_CYCLES)) chk_u (
   .core_clk(core_clk), .reset(reset), .sfr_req(sfr_req),
   .irq_enable_priority_second(irq_enable_priority_second), .dig_cmp_raw(dig_cmp_raw),
   .ana_cmp_raw(ana_cmp_raw), .sfr_rdata(sfr_rdata), .cmp_ctrl(cmp_ctrl), .low_supply_irq(low_supply_irq));

// >>> smc_cmp_model.sv
`timescale 1ns/100ps
module smc_cmp_model
   import smc_pkg::*;
(
   input  wire smc_cmp_ctrl_t cmp_ctrl,
   input  wire logic [12:0]   dv_mv,
   input  wire logic [12:0]   av_mv,
   output      logic          dig_cmp_raw,
   output      logic          ana_cmp_raw
);
   // trip levels in mV by code
   localparam logic [12:0] TRIP [4] = '{13'h1216, 13'h0C08, 13'h0B72, 13'h0A46};
   // comparators: high while supply above selected level
   assign dig_cmp_raw = dv_mv > TRIP[cmp_ctrl.dig_trip];
   assign ana_cmp_raw = av_mv > TRIP[cmp_ctrl.ana_trip];
endmodule : smc_cmp_model

// >>> tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, a); end end
module tb;
   import smc_pkg::*;
   localparam int QUAL = 20;
   logic core_clk, reset, irq_en, dig_raw, ana_raw, irq;
   logic [7:0] rdata;
   logic [12:0] dv_mv, av_mv;
   smc_sfr_req_t sfr_req;
   smc_cmp_ctrl_t ctrl;
   int fails, checks;
   smc_supply_monitor #(.QUAL_CYCLES(QUAL)) dut_u (.core_clk(core_clk), .reset(reset), .sfr_req(sfr_req),
      .irq_enable_priority_second(irq_en), .dig_cmp_raw(dig_raw), .ana_cmp_raw(ana_raw),
      .sfr_rdata(rdata), .cmp_ctrl(ctrl), .low_supply_irq(irq));
   smc_cmp_model cmp_u (.cmp_ctrl(ctrl), .dv_mv(dv_mv), .av_mv(av_mv), .dig_cmp_raw(dig_raw), .ana_cmp_raw(ana_raw));
   // clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wt
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sfr_req <= '{1'b1, a, d};
      @(posedge core_clk);
      sfr_req.wr <= 1'b0;
      #1;
   endtask : wr
   task sup(input logic [12:0] d, input logic [12:0] a);
      @(posedge core_clk);
      dv_mv <= d;
      av_mv <= a;
   endtask : sup
   task end_sim;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // watchdog
   initial begin
      #20000;
      fails++;
      end_sim;
   end
   // tests
   initial begin
      reset = 1'b1; sfr_req = '0; irq_en = 1'b1; dv_mv = 13'h1388; av_mv = 13'h1388;
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      wt(1);
      `CHK("reset image", 8'hDE, rdata)
      `CHK("reset ctrl", 5'h1E, ctrl)
      sup(13'h0BB8, 13'h0BB8);
      for (int c = 0; c < 4; c++) begin
         wr(SMC_CTRL_ADDR, {3'h0, c[1:0], c[1:0], 1'b1});
         wt(12);
         `CHK("ctrl", {c[1:0], c[1:0], 1'b1}, ctrl)
         `CHK("trip image", {c[1], c[1], 1'b0, c[1:0], c[1:0], 1'b1}, rdata & 8'hDF)
      end
      sup(13'h1388, 13'h1388);
      wt(40);
      `CHK("flag cleared", 1'b0, rdata[5])
      wr(8'hDE, 8'h00);
      wt(3);
      `CHK("unmapped", 8'hDF, rdata)
      wr(SMC_CTRL_ADDR, 8'h3F);
      wt(1);
      `CHK("soft set", 1'b1, rdata[5])
      wr(SMC_CTRL_ADDR, 8'h1F);
      wt(2);
      `CHK("soft clear", 1'b0, rdata[5])
      $display("trip test done");
      sup(13'h07D0, 13'h1388);
      repeat (2) @(posedge core_clk);
      sup(13'h1388, 13'h1388);
      wt(15);
      `CHK("glitch flag", 1'b0, rdata[5])
      $display("glitch test done");
      sup(13'h1388, 13'h07D0);
      wt(12);
      `CHK("cmp bits", 2'b10, rdata[7:6])
      `CHK("flag set", 1'b1, rdata[5])
      `CHK("irq on", 1'b1, irq)
      @(posedge core_clk) irq_en <= 1'b0;
      wt(2);
      `CHK("irq masked", 1'b0, irq)
      @(posedge core_clk) irq_en <= 1'b1;
      wr(SMC_CTRL_ADDR, 8'h1F);
      wt(3);
      `CHK("clear refused", 1'b1, rdata[5])
      sup(13'h1388, 13'h1388);
      wt(QUAL + 7);
      `CHK("flag held", 1'b1, rdata[5])
      wt(1);
      `CHK("flag qualified", 1'b0, rdata[5])
      `CHK("irq off", 1'b0, irq)
      $display("low supply test done");
      wr(SMC_CTRL_ADDR, 8'h1E);
      sup(13'h07D0, 13'h07D0);
      wt(12);
      `CHK("off flag", 8'h1E, rdata)
      sup(13'h1388, 13'h1388);
      wr(SMC_CTRL_ADDR, 8'h3E);
      wt(QUAL + 12);
      `CHK("off qual held", 8'hFE, rdata)
      $display("off test done");
      end_sim;
   end
endmodule : tb
